/* inc/ptf_pkg.sv */
package ptf_pkg;
   // pci bus commands claimed
   localparam logic [3:0] PTF_CMD_MEM_RD = 4'h6;
   localparam logic [3:0] PTF_CMD_MEM_WR = 4'h7;

   // timing
   localparam int PTF_CLK_NS = 100;
   localparam int PTF_WE_PULSE_NS = 150;
   localparam int PTF_WE_CYC = (PTF_WE_PULSE_NS + PTF_CLK_NS - 1) / PTF_CLK_NS;

   // transaction clock numbers, clock 1 is the address phase
   localparam logic [3:0] PTF_C_DECODE = 4'h2;
   localparam logic [3:0] PTF_C_DEVSEL = 4'h4;
   localparam logic [3:0] PTF_C_RD_START = 4'h2;
   localparam logic [3:0] PTF_C_RD_SAMPLE = 4'h9;
   localparam logic [3:0] PTF_C_RD_DONE = 4'hA;
   localparam logic [3:0] PTF_C_WR_START = 4'h3;
   localparam logic [3:0] PTF_C_WE_END = PTF_C_WR_START + 4'(PTF_WE_CYC);
   localparam logic [3:0] PTF_C_WR_DONE = 4'h5;
   localparam logic [3:0] PTF_C_ROM_LO = 4'h6;
   localparam logic [3:0] PTF_C_ROM_HI_START = 4'h7;
   localparam logic [3:0] PTF_C_ROM_HI = 4'hB;
   localparam logic [3:0] PTF_C_ROM_DONE = 4'hC;
   localparam logic [3:0] PTF_C_ONE = 4'h1;

   // array geometry and address fields
   localparam int PTF_BANKS = 4;
   localparam int PTF_LANES = 4;
   localparam int PTF_CE_W = PTF_BANKS * PTF_LANES;
   localparam int PTF_WIN_LSB = 25;
   localparam int PTF_SZ2_LSB = 21;
   localparam int PTF_SZ8_LSB = 23;
   localparam int PTF_SZ16_LSB = 24;
   localparam int PTF_BANK_LSB = 23;
   localparam int PTF_DEV_LSB = 2;
   localparam int PTF_DEV_W = 21;
   localparam int PTF_ROM_WIN_LSB = 16;
   localparam int PTF_ROM_AW = 17;
   localparam int PTF_ROM_DW = 16;

   typedef enum logic [1:0] {
      PTF_SZ_2M = 2'h0,
      PTF_SZ_8M = 2'h1,
      PTF_SZ_16M = 2'h2,
      PTF_SZ_32M = 2'h3
   } ptf_size_e;

   typedef enum logic [2:0] {
      PTF_ST_IDLE = 3'h0,
      PTF_ST_DECODE = 3'h1,
      PTF_ST_WAIT = 3'h3,
      PTF_ST_DATA = 3'h2,
      PTF_ST_TURN = 3'h6,
      PTF_ST_HOLD = 3'h4
   } ptf_state_e;

   typedef enum logic [1:0] {
      PTF_K_RD = 2'h0,
      PTF_K_WR = 2'h1,
      PTF_K_ROM = 2'h2
   } ptf_kind_e;

   typedef struct packed {
      logic frame_n;
      logic irdy_n;
      logic [3:0] cbe_n;
      logic [31:0] ad;
   } ptf_pin_s;

   typedef struct packed {
      logic [PTF_CE_W-1:0] ce_n;
      logic oe_n;
      logic we_n;
      logic [PTF_DEV_W-1:0] addr;
      logic [31:0] dq;
      logic dq_oe;
   } ptf_flash_s;

   typedef struct packed {
      logic [PTF_ROM_AW-1:0] addr;
      logic ce_n;
      logic oe_n;
   } ptf_rom_s;

   localparam ptf_pin_s PTF_PIN_IDLE = '{frame_n: 1'b1, irdy_n: 1'b1, cbe_n: 4'hF, ad: 32'h0};
   localparam ptf_flash_s PTF_FLASH_IDLE = '{ce_n: '1, oe_n: 1'b1, we_n: 1'b1,
                                             addr: '0, dq: 32'h0, dq_oe: 1'b0};
   localparam ptf_rom_s PTF_ROM_IDLE = '{addr: '0, ce_n: 1'b1, oe_n: 1'b1};
endpackage

/* hdl/ptf_sync.sv */
`timescale 1ns/1ps
module ptf_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // two flops, first read only by second
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;
endmodule // ptf_sync

/* hdl/ptf_bank_dec.sv */
`timescale 1ns/1ps
module ptf_bank_dec import ptf_pkg::*; (
   // address and configuration
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_base,
   input wire ptf_size_e i_size,
   // decode result
   output logic o_hit,
   output logic [PTF_BANKS-1:0] o_bank_ce,
   output logic [PTF_DEV_W-1:0] o_dev_addr
);
   logic fit;
   logic [1:0] bank;

   // R18 R21 R23: size mode picks bank
   always_comb begin
      fit = 1'b0;
      bank = 2'h0;
      case (i_size)
         PTF_SZ_2M: fit = (i_addr[PTF_WIN_LSB-1:PTF_SZ2_LSB] == '0);
         PTF_SZ_8M: fit = (i_addr[PTF_WIN_LSB-1:PTF_SZ8_LSB] == '0);
         PTF_SZ_16M: begin
            fit = !i_addr[PTF_SZ16_LSB];
            bank = {1'b0, i_addr[PTF_BANK_LSB]};
         end
         PTF_SZ_32M: begin
            fit = 1'b1;
            bank = i_addr[PTF_BANK_LSB +: 2];
         end
         default: fit = 1'b0;
      endcase
   end

   assign o_hit = fit && (i_addr[31:PTF_WIN_LSB] == i_base[31:PTF_WIN_LSB]);
   // R19: exactly one bank selected
   assign o_bank_ce = 4'h1 << bank;
   // R14: device address from upper bits
   assign o_dev_addr = i_addr[PTF_DEV_LSB +: PTF_DEV_W];
endmodule // ptf_bank_dec

/* hdl/ptf_bridge.sv */
`timescale 1ns/1ps
// Function
// R1: claim array reads with devsel asserted in clock four.
// R2: read waits clocks five to nine, data with trdy and stop in ten.
// R3: no bursts; every access ends in disconnect, stop with trdy.
// R4: master accepts disconnect and reissues with next address itself.
// R5: array write uses slow devsel and completes in five clocks with stop.
// R6: software writes read array before expecting array data.
// R7: erase is setup write then confirm write inside the block.
// R8: status commands pass as plain writes, status as plain reads.
// R9: flash accepts either of two program setup codes.
// R10: write data held valid through the strobe rising edge.
// R11: identifier reads return maker, device and lock codes by address.
// R12: clear lock bits needs reset/power-down held high.
// R13: word writes must not cross a double-word boundary.
// R14: byte lane n goes to device n at upper address bits.
// R15: software replicates command bytes over all four lanes.
// R16: bank lock is lock code, confirm code, then all ones.
// R17: one-device data steps addresses by four within a bank.
// R18: four size modes: 2, 8, 16 and 32 Mbyte.
// R19: full four by four array, still works with one or two banks.
// R20: rom reads build a double word from x16 rom in twelve clocks.
// R21: four banks of four byte-wide devices, bank from address.
// R22: bank 0 bytes go to device selects zero through three.
// R23: one bank's selects only; inactive byte enables select nothing.
// R24: write strobe low long enough, raised before data and address released.
module ptf_bridge import ptf_pkg::*; (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // pci pins
   input wire logic i_pci_frame_n,
   input wire logic i_pci_irdy_n,
   input wire logic [3:0] i_pci_cbe_n,
   input wire logic [31:0] i_pci_ad,
   output logic [31:0] o_pci_ad,
   output logic o_pci_ad_oe,
   output logic o_pci_par,
   output logic o_pci_par_oe,
   output logic o_pci_devsel_n,
   output logic o_pci_trdy_n,
   output logic o_pci_stop_n,
   output logic o_pci_ctl_oe,
   // configuration
   input wire logic [31:0] i_mem_base,
   input wire ptf_size_e i_size_mode,
   input wire logic [31:0] i_rom_base,
   input wire logic i_rom_enable,
   // flash array
   input wire logic [31:0] i_flash_dq,
   output ptf_flash_s o_flash,
   output logic o_flash_reset_powerdown_n,
   // expansion rom
   input wire logic [PTF_ROM_DW-1:0] i_rom_dq,
   output ptf_rom_s o_rom
);
   ptf_pin_s pin_raw;
   ptf_pin_s pin_s;
   logic [31:0] fl_dq_s;
   logic [PTF_ROM_DW-1:0] rom_dq_s;
   ptf_state_e state_q, state_d;
   ptf_kind_e kind_q, kind_d;
   logic [3:0] cnt_q, cnt_d;
   logic [3:0] cmd_q, cmd_d;
   logic [3:0] be_q, be_d;
   logic [31:0] addr_q, addr_d;
   logic [31:0] data_q, data_d;
   logic arr_hit;
   logic rom_hit;
   logic [PTF_BANKS-1:0] bank_ce;
   logic [PTF_DEV_W-1:0] dev_addr;
   logic [3:0] done_cnt;
   logic active;
   ptf_flash_s fl_q, fl_d;
   ptf_rom_s rom_q, rom_d;
   logic par_q, par_d;
   logic par_oe_q, par_oe_d;
   logic rp_q;
   logic fl_on;
   logic rom_on;
   logic [31:0] mem_base_s;
   logic [1:0] size_bits;
   ptf_size_e size_s;
   logic [31:0] rom_base_s;
   logic rom_en_s;
   logic rp_d;

   assign pin_raw = '{frame_n: i_pci_frame_n, irdy_n: i_pci_irdy_n,
                      cbe_n: i_pci_cbe_n, ad: i_pci_ad};

   ptf_sync #(.W($bits(ptf_pin_s)), .RESET_VAL(PTF_PIN_IDLE)) u_pin_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_d(pin_raw),
      .o_q(pin_s)
   );

   ptf_sync #(.W(32 + PTF_ROM_DW), .RESET_VAL('0)) u_dq_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_d({i_flash_dq, i_rom_dq}),
      .o_q({fl_dq_s, rom_dq_s})
   );

   // configuration straps pass two flops like the pci and data pins
   ptf_sync #(.W(32 + $bits(size_bits) + 32 + 1), .RESET_VAL('0)) u_cfg_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_d({i_mem_base, i_size_mode, i_rom_base, i_rom_enable}),
      .o_q({mem_base_s, size_bits, rom_base_s, rom_en_s})
   );
   assign size_s = ptf_size_e'(size_bits);

   ptf_bank_dec u_dec (
      .i_addr(addr_q),
      .i_base(mem_base_s),
      .i_size(size_s),
      .o_hit(arr_hit),
      .o_bank_ce(bank_ce),
      .o_dev_addr(dev_addr)
   );

   assign rom_hit = rom_en_s &&
                    (addr_q[31:PTF_ROM_WIN_LSB] == rom_base_s[31:PTF_ROM_WIN_LSB]);

   // clock at which trdy and stop come
   always_comb begin
      case (kind_q)
         PTF_K_WR: done_cnt = PTF_C_WR_DONE;
         PTF_K_ROM: done_cnt = PTF_C_ROM_DONE;
         default: done_cnt = PTF_C_RD_DONE;
      endcase
   end

   // transaction sequencer
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      cnt_d = cnt_q;
      cmd_d = cmd_q;
      be_d = be_q;
      addr_d = addr_q;
      data_d = data_q;
      case (state_q)
         PTF_ST_IDLE: begin
            if (!pin_s.frame_n) begin
               addr_d = pin_s.ad;
               cmd_d = pin_s.cbe_n;
               cnt_d = PTF_C_DECODE;
               state_d = PTF_ST_DECODE;
            end
         end
         PTF_ST_DECODE: begin
            be_d = pin_s.cbe_n;
            if (cmd_q == PTF_CMD_MEM_RD && rom_hit) begin
               kind_d = PTF_K_ROM;
               cnt_d = cnt_q + PTF_C_ONE;
               state_d = PTF_ST_WAIT;
            end else if (cmd_q == PTF_CMD_MEM_RD && arr_hit) begin
               kind_d = PTF_K_RD;
               cnt_d = cnt_q + PTF_C_ONE;
               state_d = PTF_ST_WAIT;
            end else if (cmd_q == PTF_CMD_MEM_WR && arr_hit) begin
               // write data taken once the master has it ready
               if (!pin_s.irdy_n) begin
                  data_d = pin_s.ad;
                  kind_d = PTF_K_WR;
                  cnt_d = cnt_q + PTF_C_ONE;
                  state_d = PTF_ST_WAIT;
               end else if (pin_s.frame_n && pin_s.irdy_n) begin
                  // master gave up before its data phase
                  state_d = PTF_ST_HOLD;
               end
            end else begin
               state_d = PTF_ST_HOLD;
            end
         end
         PTF_ST_WAIT: begin
            cnt_d = cnt_q + PTF_C_ONE;
            // R2: flash byte lanes sampled
            if (kind_q == PTF_K_RD && cnt_q == PTF_C_RD_SAMPLE) begin
               data_d = fl_dq_s;
            end
            // R20: two rom halves sampled
            if (kind_q == PTF_K_ROM && cnt_q == PTF_C_ROM_LO) begin
               data_d[PTF_ROM_DW-1:0] = rom_dq_s;
            end
            if (kind_q == PTF_K_ROM && cnt_q == PTF_C_ROM_HI) begin
               data_d[31:PTF_ROM_DW] = rom_dq_s;
            end
            if (cnt_d == done_cnt) begin
               state_d = PTF_ST_DATA;
            end
         end
         PTF_ST_DATA: begin
            // R3: single data phase then leave
            if (!pin_s.irdy_n) begin
               state_d = PTF_ST_TURN;
            end
         end
         PTF_ST_TURN: state_d = PTF_ST_HOLD;
         PTF_ST_HOLD: begin
            if (pin_s.frame_n && pin_s.irdy_n) begin
               state_d = PTF_ST_IDLE;
            end
         end
         default: state_d = PTF_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= PTF_ST_IDLE;
         kind_q <= PTF_K_RD;
         cnt_q <= '0;
         cmd_q <= '0;
         be_q <= 4'hF;
         addr_q <= '0;
         data_q <= '0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         be_q <= be_d;
         addr_q <= addr_d;
         data_q <= data_d;
      end
   end

   // target handshake on the pci side
   assign active = (state_q == PTF_ST_WAIT) || (state_q == PTF_ST_DATA);
   // R1 R5: slow devsel from clock four
   assign o_pci_devsel_n = !(active && cnt_q >= PTF_C_DEVSEL);
   // R2 R3 R5: trdy with stop, disconnect
   assign o_pci_trdy_n = !(state_q == PTF_ST_DATA);
   assign o_pci_stop_n = !(state_q == PTF_ST_DATA);
   assign o_pci_ctl_oe = active || (state_q == PTF_ST_TURN);
   // R8: read data returned as plain read
   assign o_pci_ad = data_q;
   assign o_pci_ad_oe = (state_q == PTF_ST_DATA) && (kind_q != PTF_K_WR);
   assign o_pci_par = par_q;
   assign o_pci_par_oe = par_oe_q;

   assign fl_on = (state_d == PTF_ST_WAIT) || (state_d == PTF_ST_DATA);
   assign rom_on = fl_on && (kind_d == PTF_K_ROM) && (cnt_d >= PTF_C_RD_START);

   // parity over ad and byte enables, one clock behind the data
   always_comb begin
      par_d = ^{data_q, be_q};
      par_oe_d = o_pci_ad_oe;
      rp_d = 1'b1;
   end

   // flash and rom strobes
   always_comb begin
      fl_d = PTF_FLASH_IDLE;
      rom_d = PTF_ROM_IDLE;
      fl_d.addr = dev_addr;
      fl_d.dq = data_d;
      // R14 R22 R23: lane n to device n of one bank
      if (fl_on && ((kind_d == PTF_K_RD && cnt_d >= PTF_C_RD_START) ||
                    (kind_d == PTF_K_WR && cnt_d >= PTF_C_WR_START))) begin
         for (int b = 0; b < PTF_BANKS; b++) begin
            for (int l = 0; l < PTF_LANES; l++) begin
               fl_d.ce_n[b * PTF_LANES + l] = !(bank_ce[b] && !be_d[l]);
            end
         end
      end
      // R8 R11: reads pass any flash mode's data
      fl_d.oe_n = !(fl_on && kind_d == PTF_K_RD && cnt_d >= PTF_C_RD_START);
      // R10 R24: data held, strobe raised first
      fl_d.dq_oe = fl_on && (kind_d == PTF_K_WR) && (cnt_d >= PTF_C_WR_START);
      // R9 R15: command bytes passed unchanged
      fl_d.we_n = !((state_d == PTF_ST_WAIT) && (kind_d == PTF_K_WR) &&
                    (cnt_d >= PTF_C_WR_START) && (cnt_d < PTF_C_WE_END));
      // R20: low then high half word
      rom_d.addr = {addr_q[PTF_DEV_LSB +: PTF_ROM_AW - 1], cnt_d >= PTF_C_ROM_HI_START};
      rom_d.ce_n = !rom_on;
      rom_d.oe_n = !rom_on;
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fl_q <= PTF_FLASH_IDLE;
         rom_q <= PTF_ROM_IDLE;
         par_q <= 1'b0;
         par_oe_q <= 1'b0;
         rp_q <= 1'b0;
      end else begin
         fl_q <= fl_d;
         rom_q <= rom_d;
         par_q <= par_d;
         par_oe_q <= par_oe_d;
         // R12: reset/power-down held high
         rp_q <= rp_d;
      end
   end

   assign o_flash = fl_q;
   assign o_rom = rom_q;
   assign o_flash_reset_powerdown_n = rp_q;
endmodule // ptf_bridge

/* bench/ptf_bridge_checker.sv */
`timescale 1ns/1ps
module ptf_bridge_checker import ptf_pkg::*; (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // pci outputs
   input wire logic o_pci_ad_oe,
   input wire logic o_pci_devsel_n,
   input wire logic o_pci_trdy_n,
   input wire logic o_pci_stop_n,
   // flash and rom outputs
   input wire ptf_flash_s o_flash,
   input wire logic o_flash_reset_powerdown_n,
   input wire ptf_rom_s o_rom
);
   logic [PTF_BANKS-1:0] bank_act;
   always_comb begin
      for (int b = 0; b < PTF_BANKS; b++)
         bank_act[b] = ~&o_flash.ce_n[b*PTF_LANES+:PTF_LANES];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_devsel_slow: assert property ($fell(o_flash.oe_n) |-> ##1 $fell(o_pci_devsel_n))
      else $error("devsel not one clock after read start");
   a_read_wait: assert property ($fell(o_pci_devsel_n) && !o_flash.oe_n |->
      ##1 o_pci_trdy_n [*5] ##1 (!o_pci_trdy_n && !o_pci_stop_n))
      else $error("array read ready not in clock ten");
   a_write_fast: assert property ($fell(o_pci_devsel_n) && !o_flash.we_n |->
      ##1 (!o_pci_trdy_n && !o_pci_stop_n && o_flash.we_n))
      else $error("write not done in clock five");
   a_rom_time: assert property ($fell(o_pci_devsel_n) && !o_rom.oe_n |->
      ##1 o_pci_trdy_n [*7] ##1 (!o_pci_trdy_n && !o_pci_stop_n))
      else $error("rom read ready not in clock twelve");
   a_disconnect_only: assert property (!o_pci_trdy_n |-> !o_pci_stop_n && !o_pci_devsel_n)
      else $error("trdy without stop");
   a_one_bank: assert property ($onehot0(bank_act))
      else $error("more than one bank selected");
   a_strobe_hold: assert property ($rose(o_flash.we_n) |-> o_flash.dq_oe &&
      $stable(o_flash.dq) && $stable(o_flash.addr) && !(&o_flash.ce_n))
      else $error("write data not held through strobe rise");
   a_strobe_width: assert property ($fell(o_flash.we_n) |-> ##1 !o_flash.we_n ##1 o_flash.we_n)
      else $error("write strobe width wrong");
   a_rp_high: assert property ($past(i_reset_n) |-> o_flash_reset_powerdown_n)
      else $error("reset power-down not high");
   a_read_drive: assert property (o_pci_ad_oe |-> !o_pci_trdy_n && !o_flash.dq_oe)
      else $error("ad driven outside read data phase");
endmodule // ptf_bridge_checker

/* bench/ptf_flash_model.sv */
`timescale 1ns/1ps
module ptf_flash_model import ptf_pkg::*; (
   // flash array
   input wire ptf_flash_s i_flash,
   output logic [31:0] o_flash_dq,
   // expansion rom
   input wire ptf_rom_s i_rom,
   output logic [PTF_ROM_DW-1:0] o_rom_dq
);
   logic [7:0] mem [PTF_CE_W][64];
   initial begin
      for (int i = 0; i < PTF_CE_W; i++)
         for (int j = 0; j < 64; j++)
            mem[i][j] = 8'(i * 64 + j);
      o_flash_dq = 32'h0;
      o_rom_dq = 16'h0;
   end
   always @(posedge i_flash.we_n) begin
      for (int i = 0; i < PTF_CE_W; i++)
         if (!i_flash.ce_n[i])
            mem[i][i_flash.addr[5:0]] = i_flash.dq[8*(i%4)+:8];
   end
   // lane n answers from device n, else inverted
   always @(i_flash) begin
      for (int l = 0; l < PTF_LANES; l++) begin
         o_flash_dq[8*l+:8] = ~o_flash_dq[8*l+:8];
         for (int b = 0; b < PTF_BANKS; b++)
            if (!i_flash.ce_n[b*4+l] && !i_flash.oe_n)
               o_flash_dq[8*l+:8] = mem[b*4+l][i_flash.addr[5:0]];
      end
   end
   always @(i_rom) begin
      o_rom_dq = (!i_rom.ce_n && !i_rom.oe_n) ? i_rom.addr[15:0] ^ 16'h5A5A : ~o_rom_dq;
   end
endmodule // ptf_flash_model

/* bench/ptf_bridge_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module ptf_bridge_test import ptf_pkg::*;;
   localparam logic [31:0] BASE = 32'h0200_0000;
   localparam logic [31:0] ROMB = 32'h000C_0000;
   logic clk = 1'b0, rst_n = 1'b0, frame_n = 1'b1, irdy_n = 1'b1, rom_en = 1'b0;
   logic [3:0] cbe_n = 4'hF;
   logic [31:0] tb_ad = 32'h0, ad_wire, pci_ad, fdq, r, e;
   logic ad_oe, devsel_n, trdy_n, stop_n, rp_n, h, par, par_oe, ctl_oe;
   ptf_size_e size = PTF_SZ_32M;
   ptf_flash_s flash;
   ptf_rom_s rom;
   logic [15:0] rdq;
   int n_errors = 0, check_count = 0, cycles = 0;
   logic [31:0] seq [5] = '{32'h2020_2020, 32'hD0D0_D0D0, 32'h7777_7777, 32'hD0D0_D0D0,
                            32'hFFFF_FFFF};
   always #50 clk = ~clk;
   assign ad_wire = ad_oe ? pci_ad : tb_ad;
   ptf_bridge dut (.i_clk(clk), .i_reset_n(rst_n), .i_pci_frame_n(frame_n),
      .i_pci_irdy_n(irdy_n), .i_pci_cbe_n(cbe_n), .i_pci_ad(ad_wire), .o_pci_ad(pci_ad),
      .o_pci_ad_oe(ad_oe), .o_pci_par(par), .o_pci_par_oe(par_oe), .o_pci_devsel_n(devsel_n),
      .o_pci_trdy_n(trdy_n), .o_pci_stop_n(stop_n), .o_pci_ctl_oe(ctl_oe), .i_mem_base(BASE),
      .i_size_mode(size), .i_rom_base(ROMB), .i_rom_enable(rom_en), .i_flash_dq(fdq),
      .o_flash(flash), .o_flash_reset_powerdown_n(rp_n), .i_rom_dq(rdq), .o_rom(rom));
   ptf_flash_model model (.i_flash(flash), .o_flash_dq(fdq), .i_rom(rom), .o_rom_dq(rdq));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         complete_run();
      end
   end
   function automatic logic [31:0] init_dw(int b, int a);
      for (int l = 0; l < 4; l++)
         init_dw[8*l+:8] = 8'((b * 4 + l) * 64 + a);
   endfunction
   task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd, output logic hit);
      hit = 1'b0;
      @(negedge clk);
      frame_n = 1'b0;
      cbe_n = cmd;
      tb_ad = a;
      @(negedge clk);
      frame_n = 1'b1;
      irdy_n = 1'b0;
      cbe_n = be;
      tb_ad = wd;
      for (int n = 0; n < 40 && !(hit && !trdy_n); n++) begin
         @(negedge clk);
         if (!devsel_n) hit = 1'b1;
      end
      rd = ad_wire;
      `CHK("stop", hit, !stop_n)
      irdy_n = 1'b1;
      cbe_n = 4'hF;
      @(negedge clk);
      `CHK("turnaround drive", hit, ctl_oe)
      `CHK("parity drive", hit && cmd == PTF_CMD_MEM_RD, par_oe)
      if (hit && cmd == PTF_CMD_MEM_RD) `CHK("parity", ^{rd, be}, par)
      repeat (5) @(negedge clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
      xfer(PTF_CMD_MEM_WR, a, be, d, r, h);
      `CHK("write claim", 1'b1, h)
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      xfer(PTF_CMD_MEM_RD, a, 4'h0, 32'h0, r, h);
      `CHK("read claim", 1'b1, h)
      `CHK("read data", x, r)
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("reset power-down high", 1'b1, rp_n)
      rd(BASE + 32'h10, init_dw(0, 4));
      wr(BASE + 32'h10, 4'h0, 32'h1122_3344);
      rd(BASE + 32'h10, 32'h1122_3344);
      wr(BASE + 32'h20, 4'hE, 32'h0000_00AB);
      e = init_dw(0, 8);
      e[7:0] = 8'hAB;
      rd(BASE + 32'h20, e);
      xfer(4'h2, BASE, 4'h0, 32'h0, r, h);
      `CHK("other command", 1'b0, h)
      $display("test access done");
      for (int m = 0; m < 4; m++) begin
         size = ptf_size_e'(m);
         for (int k = 0; k < 3; k++) begin
            xfer(PTF_CMD_MEM_RD, BASE + (k == 0 ? 32'h20_0000 : k == 1 ? 32'h80_0000 :
               32'h180_0000), 4'h0, 32'h0, r, h);
            `CHK("size hit", k < m || (m == 1 && k == 0), h)
            if (h) `CHK("bank data", init_dw(k == 2 ? 3 : k, 0), r)
         end
      end
      $display("test size done");
      // reissue one byte per transaction, address steps by four
      for (int i = 0; i < 4; i++)
         wr(BASE + 32'h180_0040 + 32'(4 * i), 4'hE, {24'h0, 8'(8'h40 >> (i % 2 * 2))});
      for (int i = 0; i < 5; i++)
         wr(BASE + 32'h180_0040, 4'h0, seq[i]);
      rd(BASE + 32'h180_0040, 32'hFFFF_FFFF);
      $display("test command done");
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("reset power-down low", 1'b0, rp_n)
      `CHK("reset devsel", 1'b1, devsel_n)
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("power-down after reset", 1'b1, rp_n)
      $display("test reset done");
      xfer(PTF_CMD_MEM_RD, ROMB + 32'h24, 4'h0, 32'h0, r, h);
      `CHK("rom off", 1'b0, h)
      rom_en = 1'b1;
      e = {{ROMB[16:2] | 15'h9, 1'b1} ^ 16'h5A5A, {ROMB[16:2] | 15'h9, 1'b0} ^ 16'h5A5A};
      rd(ROMB + 32'h24, e);
      $display("test rom done");
      complete_run();
   end
endmodule // ptf_bridge_test
bind ptf_bridge ptf_bridge_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .o_pci_ad_oe(o_pci_ad_oe), .o_pci_devsel_n(o_pci_devsel_n), .o_pci_trdy_n(o_pci_trdy_n),
   .o_pci_stop_n(o_pci_stop_n), .o_flash(o_flash),
   .o_flash_reset_powerdown_n(o_flash_reset_powerdown_n), .o_rom(o_rom));
